// ===== tax_pkg.sv
package tax_pkg;
    localparam int PTR_W = 21;
    localparam logic [PTR_W-1:0] PTR_ONE = 21'h000001;
    localparam logic [PTR_W-1:0] PTR_RST = 21'h000000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;
    localparam logic [1:0] OPT_NONE = 2'h0;
    localparam logic [1:0] OPT_POSTINC = 2'h1;
    localparam logic [1:0] OPT_POSTDEC = 2'h2;
    localparam logic [1:0] OPT_PREINC = 2'h3;
    localparam logic [13:0] OPC_TBL_HI = 14'h0002;
    localparam logic [13:0] OPC_TBW_HI = 14'h0003;
    localparam logic [6:0] OPC_TST_HI = 7'h33;
    localparam logic [7:0] OPC_XORL_HI = 8'h0A;
    localparam logic [5:0] OPC_XORF_HI = 6'h06;
    localparam int BIT_A = 8;
    localparam int BIT_D = 9;
    localparam int FLAG_N = 1;
    localparam int FLAG_Z = 0;
    localparam logic [3:0] ACCESS_BANK = 4'h0;
    typedef enum logic [2:0] {OP_NONE, OP_TABLE_READ, OP_TABLE_WRITE, OP_TST, OP_XORL, OP_XORF} tax_op_t;
endpackage : tax_pkg

// ===== tax_decode.sv
`timescale 1ns/10ps
module tax_decode (
    input  wire logic [15:0]   instr_i,  // Instruction word
    output tax_pkg::tax_op_t   op_o,     // Decoded class
    output logic [1:0]         opt_o     // Pointer option
);
    always_comb begin
        op_o  = tax_pkg::OP_NONE;
        opt_o = instr_i[1:0];
        if (instr_i[15:2] == tax_pkg::OPC_TBL_HI) begin
            op_o = tax_pkg::OP_TABLE_READ;
        end else if (instr_i[15:2] == tax_pkg::OPC_TBW_HI) begin
            op_o = tax_pkg::OP_TABLE_WRITE;
        end else if (instr_i[15:9] == tax_pkg::OPC_TST_HI) begin
            op_o = tax_pkg::OP_TST;
        end else if (instr_i[15:8] == tax_pkg::OPC_XORL_HI) begin
            op_o = tax_pkg::OP_XORL;
        end else if (instr_i[15:10] == tax_pkg::OPC_XORF_HI) begin
            op_o = tax_pkg::OP_XORF;
        end
    end
endmodule : tax_decode

// ===== tax_core.sv
`timescale 1ns/10ps
module tax_core (
    input  wire logic                     SYS_CLK_I,      // 10 MHz clock
    input  wire logic                     SRST_I,         // Sync reset, high
    input  wire logic                     INSTR_VALID_I,  // Instruction offered
    input  wire logic [15:0]              INSTR_I,        // Instruction word
    input  wire logic                     NEXT_TWO_WORD_I,// Prefetched instr is two-word
    input  wire logic [7:0]               REG_RDATA_I,    // File register read data
    input  wire logic [3:0]               BANK_SELECT_REGISTER_I, // Bank select register
    input  wire logic [7:0]               PM_RDATA_I,     // Program memory byte
    input  wire logic                     PM_BUSY_I,      // Long write in progress
    output logic                          BUSY_O,         // Instruction executing
    output logic [1:0]                    PHASE_O,        // Current Q phase
    output logic [11:0]                   REG_ADDR_O,     // File register address
    output logic                          REG_WE_O,       // File register write
    output logic [7:0]                    REG_WDATA_O,    // File register write data
    output logic [7:0]                    WORKING_REGISTER_O, // Working register
    output logic [1:0]                    FLAGS_O,        // N and Z flags
    output logic                          FLUSH_O,        // Discard prefetched word
    output logic [20:0]                   PM_ADDR_O,      // Program memory byte address
    output logic                          PM_RD_O,        // Program memory read
    output logic                          PM_WR_O,        // Memory or holding write
    output logic [7:0]                    PM_WDATA_O,     // Table latch to memory
    output logic [7:0]                    TABLE_LATCH_O   // Table latch
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {S_IDLE, S_EXEC, S_TBL2, S_SKIP1, S_SKIP2} tax_state_t;

    tax_state_t               state_q;
    tax_pkg::tax_op_t         op_dec, op_q;
    logic [1:0]               opt_dec, opt_q;
    logic [1:0]               phase_q;
    logic [15:0]              instr_q;
    logic [tax_pkg::PTR_W-1:0] table_pointer_q;
    logic [7:0]               table_latch_q;
    logic [7:0]               working_register_q;
    logic [7:0]               operand_q;
    logic [1:0]               flags_q;
    logic                     two_word_q;
    logic [7:0]               xor_res;
    logic                     wr_done_q;

    function automatic logic [1:0] nz_of(input logic [7:0] v);
        nz_of = {v[7], v == tax_pkg::BYTE_ZERO};
    endfunction : nz_of

    tax_decode u_dec (
        .instr_i (INSTR_I),
        .op_o    (op_dec),
        .opt_o   (opt_dec)
    );

    assign xor_res = working_register_q ^ (op_q == tax_pkg::OP_XORL ? instr_q[7:0] : operand_q);

    ////////////////////////////////////////////////////////////////////////
    // four-phase cycle
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I || state_q == S_IDLE) begin
            phase_q <= tax_pkg::PH_Q1;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            state_q    <= S_IDLE;
            op_q       <= tax_pkg::OP_NONE;
            opt_q      <= tax_pkg::OPT_NONE;
            instr_q    <= 16'h0000;
            two_word_q <= 1'b0;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (INSTR_VALID_I && op_dec != tax_pkg::OP_NONE) begin
                        state_q    <= S_EXEC;
                        op_q       <= op_dec;
                        opt_q      <= opt_dec;
                        instr_q    <= INSTR_I;
                        two_word_q <= NEXT_TWO_WORD_I;
                    end
                end
                S_EXEC: begin
                    if (phase_q == tax_pkg::PH_Q4) begin
                        if (op_q == tax_pkg::OP_TABLE_READ || op_q == tax_pkg::OP_TABLE_WRITE) begin
                            state_q <= S_TBL2;
                        end else if (op_q == tax_pkg::OP_TST && operand_q == tax_pkg::BYTE_ZERO) begin
                            state_q <= S_SKIP1;
                        end else begin
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_TBL2: begin
                    if (phase_q == tax_pkg::PH_Q4 && !(op_q == tax_pkg::OP_TABLE_WRITE && PM_BUSY_I)) begin
                        state_q <= S_IDLE;
                    end
                end
                S_SKIP1: begin
                    if (phase_q == tax_pkg::PH_Q4) begin
                        state_q <= two_word_q ? S_SKIP2 : S_IDLE;
                    end
                end
                S_SKIP2: begin
                    if (phase_q == tax_pkg::PH_Q4) begin
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bank selection
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            REG_ADDR_O <= 12'h000;
            operand_q  <= tax_pkg::BYTE_ZERO;
        end else begin
            if (state_q == S_IDLE && INSTR_VALID_I) begin
                REG_ADDR_O <= {INSTR_I[tax_pkg::BIT_A] ? BANK_SELECT_REGISTER_I : tax_pkg::ACCESS_BANK, INSTR_I[7:0]};
            end
            if (state_q == S_EXEC && phase_q == tax_pkg::PH_Q2) begin
                operand_q <= REG_RDATA_I;
            end
        end
    end

    // xor result and flags, tables leave flags
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            working_register_q <= tax_pkg::BYTE_ZERO;
            flags_q            <= 2'h0;
            REG_WE_O           <= 1'b0;
            REG_WDATA_O        <= tax_pkg::BYTE_ZERO;
        end else begin
            REG_WE_O <= 1'b0;
            if (state_q == S_EXEC && phase_q == tax_pkg::PH_Q3) begin
                if (op_q == tax_pkg::OP_XORL) begin
                    working_register_q <= xor_res;
                    flags_q            <= nz_of(xor_res);
                end else if (op_q == tax_pkg::OP_XORF) begin
                    flags_q <= nz_of(xor_res);
                    if (instr_q[tax_pkg::BIT_D]) begin
                        REG_WE_O    <= 1'b1;
                        REG_WDATA_O <= xor_res;
                    end else begin
                        working_register_q <= xor_res;
                    end
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            FLUSH_O <= 1'b0;
        end else begin
            FLUSH_O <= state_q == S_EXEC && phase_q == tax_pkg::PH_Q4 && op_q == tax_pkg::OP_TST
                       && operand_q == tax_pkg::BYTE_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // byte pointer, update options
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            table_pointer_q <= tax_pkg::PTR_RST;
        end else if (op_q == tax_pkg::OP_TABLE_READ || op_q == tax_pkg::OP_TABLE_WRITE) begin
            if (state_q == S_EXEC && phase_q == tax_pkg::PH_Q4 && opt_q == tax_pkg::OPT_PREINC) begin
                table_pointer_q <= table_pointer_q + tax_pkg::PTR_ONE;
            end else if (state_q == S_TBL2 && phase_q == tax_pkg::PH_Q4
                         && !(op_q == tax_pkg::OP_TABLE_WRITE && PM_BUSY_I)) begin
                if (opt_q == tax_pkg::OPT_POSTINC) begin
                    table_pointer_q <= table_pointer_q + tax_pkg::PTR_ONE;
                end else if (opt_q == tax_pkg::OPT_POSTDEC) begin
                    table_pointer_q <= table_pointer_q - tax_pkg::PTR_ONE;
                end
            end
        end
    end

    // one write per stretch
    // Without this the write would repeat, and restart a long write, every pass through Q3
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I || state_q == S_IDLE) begin
            wr_done_q <= 1'b0;
        end else if (PM_WR_O) begin
            wr_done_q <= 1'b1;
        end
    end

    // bit 0 carried to memory as byte select; write latch out
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            PM_RD_O    <= 1'b0;
            PM_WR_O    <= 1'b0;
            PM_ADDR_O  <= tax_pkg::PTR_RST;
            PM_WDATA_O <= tax_pkg::BYTE_ZERO;
        end else begin
            PM_ADDR_O  <= table_pointer_q;
            PM_WDATA_O <= table_latch_q;
            PM_RD_O    <= state_q == S_TBL2 && phase_q == tax_pkg::PH_Q1 && op_q == tax_pkg::OP_TABLE_READ;
            PM_WR_O    <= state_q == S_TBL2 && phase_q == tax_pkg::PH_Q3 && op_q == tax_pkg::OP_TABLE_WRITE
                          && !wr_done_q;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            table_latch_q <= tax_pkg::BYTE_ZERO;
        end else if (state_q == S_TBL2 && phase_q == tax_pkg::PH_Q3 && op_q == tax_pkg::OP_TABLE_READ) begin
            table_latch_q <= PM_RDATA_I;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            BUSY_O             <= 1'b0;
            PHASE_O            <= tax_pkg::PH_Q1;
            WORKING_REGISTER_O <= tax_pkg::BYTE_ZERO;
            FLAGS_O            <= 2'h0;
            TABLE_LATCH_O      <= tax_pkg::BYTE_ZERO;
        end else begin
            BUSY_O             <= state_q != S_IDLE;
            PHASE_O            <= phase_q;
            WORKING_REGISTER_O <= working_register_q;
            FLAGS_O            <= flags_q;
            TABLE_LATCH_O      <= table_latch_q;
        end
    end
endmodule : tax_core

// ===== tax_core_monitor.sv
`timescale 1ns/10ps
module tax_core_chk (
    input wire logic        SYS_CLK_I,    // Clock
    input wire logic        SRST_I,       // Reset
    input wire logic [7:0]  REG_RDATA_I,  // Register data
    input wire logic        BUSY_O,       // Busy
    input wire logic [1:0]  PHASE_O,      // Phase
    input wire logic        REG_WE_O,     // Register write
    input wire logic [7:0]  REG_WDATA_O,  // Register data out
    input wire logic [7:0]  WORKING_REGISTER_O, // Working register
    input wire logic [1:0]  FLAGS_O,      // N and Z
    input wire logic        FLUSH_O,      // Flush
    input wire logic [20:0] PM_ADDR_O,    // Byte address
    input wire logic        PM_RD_O,      // Memory read
    input wire logic        PM_WR_O,      // Memory write
    input wire logic [7:0]  PM_WDATA_O,   // Memory data
    input wire logic [7:0]  TABLE_LATCH_O // Table latch
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SRST_I);
    flush_pulse_a : assert property (FLUSH_O |=> !FLUSH_O) else $error("flush longer than one clock");
    flush_zero_a : assert property (FLUSH_O |-> REG_RDATA_I == 8'h00) else $error("flush on nonzero");
    we_pulse_a : assert property (REG_WE_O |=> !REG_WE_O) else $error("write pulse too long");
    xor_data_a : assert property (REG_WE_O |-> REG_WDATA_O == (WORKING_REGISTER_O ^ REG_RDATA_I))
        else $error("register xor result wrong");
    work_flags_a : assert property ($changed(WORKING_REGISTER_O)
        |-> FLAGS_O == {WORKING_REGISTER_O[7], WORKING_REGISTER_O == 8'h00})
        else $error("flags disagree with working register");
    phase_step_a : assert property (BUSY_O && $past(BUSY_O) |-> PHASE_O == $past(PHASE_O) + 2'h1)
        else $error("phase did not advance");
    rd_wr_excl_a : assert property (!(PM_RD_O && PM_WR_O)) else $error("read and write together");
    rd_addr_hold_a : assert property (PM_RD_O |=> $stable(PM_ADDR_O)) else $error("address moved in read");
    wr_latch_a : assert property (PM_WR_O |-> PM_WDATA_O == TABLE_LATCH_O) else $error("write data not latch");
    wr_flags_a : assert property (PM_WR_O |-> FLAGS_O == $past(FLAGS_O, 4)) else $error("flags moved in write");
    reset_clear_a : assert property ($fell(SRST_I) |-> !BUSY_O && WORKING_REGISTER_O == 8'h00
        && TABLE_LATCH_O == 8'h00) else $error("outputs not cleared by reset");
    cover property (FLUSH_O);
    cover property (PM_WR_O);
    cover property (REG_WE_O);
endmodule : tax_core_chk
bind tax_core tax_core_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I), .REG_RDATA_I(REG_RDATA_I),
    .BUSY_O(BUSY_O), .PHASE_O(PHASE_O), .REG_WE_O(REG_WE_O), .REG_WDATA_O(REG_WDATA_O),
    .WORKING_REGISTER_O(WORKING_REGISTER_O), .FLAGS_O(FLAGS_O),
    .FLUSH_O(FLUSH_O), .PM_ADDR_O(PM_ADDR_O), .PM_RD_O(PM_RD_O), .PM_WR_O(PM_WR_O),
    .PM_WDATA_O(PM_WDATA_O), .TABLE_LATCH_O(TABLE_LATCH_O));

// ===== tax_pm_model.sv
`timescale 1ns/10ps
module tax_pm_model (
    input  wire logic        clk_i,    // Clock
    input  wire logic        long_i,   // Long write mode
    input  wire logic [20:0] addr_i,   // Byte address
    input  wire logic        rd_i,     // Read strobe
    input  wire logic        wr_i,     // Write strobe
    input  wire logic [7:0]  wdata_i,  // Write byte
    output logic [7:0]       rdata_o,  // Read byte
    output logic             busy_o    // Long write busy
);
    logic [7:0] mem [256];
    logic [3:0] cnt_q;
    logic [7:0] junk_q;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3C;
        cnt_q = 4'h0;
        junk_q = 8'hA5;
    end
    // Busy already on the edge that lands a long write, so the core stretches
    assign busy_o = (cnt_q != 4'h0) || (wr_i && long_i);
    // Byte read lands one clock after the strobe, junk otherwise
    always @(posedge clk_i) begin
        junk_q <= ~junk_q;
        rdata_o <= rd_i ? mem[addr_i[7:0]] : junk_q;
        if (wr_i) mem[addr_i[7:0]] <= wdata_i;
        if (wr_i && long_i) cnt_q <= 4'hA;
        else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
endmodule : tax_pm_model

// ===== tb.sv
`timescale 1ns/10ps
module tb;
    logic SYS_CLK_I = 1'b0, SRST_I = 1'b1, INSTR_VALID_I = 1'b0, NEXT_TWO_WORD_I = 1'b0, long_q = 1'b0;
    logic [15:0] INSTR_I = 16'h0000;
    logic [7:0] REG_RDATA_I = 8'h00, REG_WDATA_O, WORKING_REGISTER_O, PM_RDATA_I, PM_WDATA_O, TABLE_LATCH_O, wd_seen;
    logic [3:0] BANK_SELECT_REGISTER_I = 4'h0;
    logic [1:0] PHASE_O, FLAGS_O, fl_save;
    logic [11:0] REG_ADDR_O;
    logic [20:0] PM_ADDR_O, p;
    logic PM_BUSY_I, BUSY_O, REG_WE_O, FLUSH_O, PM_RD_O, PM_WR_O, we_seen, fl_seen;
    int miscompares = 0, n_tests = 0, cyc = 0, n, n1, nr;
    logic [7:0] lat;
    tax_core u_dut (.SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I), .INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I),
        .NEXT_TWO_WORD_I(NEXT_TWO_WORD_I), .REG_RDATA_I(REG_RDATA_I),
        .BANK_SELECT_REGISTER_I(BANK_SELECT_REGISTER_I), .PM_RDATA_I(PM_RDATA_I),
        .PM_BUSY_I(PM_BUSY_I), .BUSY_O(BUSY_O), .PHASE_O(PHASE_O), .REG_ADDR_O(REG_ADDR_O), .REG_WE_O(REG_WE_O),
        .REG_WDATA_O(REG_WDATA_O), .WORKING_REGISTER_O(WORKING_REGISTER_O), .FLAGS_O(FLAGS_O), .FLUSH_O(FLUSH_O),
        .PM_ADDR_O(PM_ADDR_O), .PM_RD_O(PM_RD_O), .PM_WR_O(PM_WR_O), .PM_WDATA_O(PM_WDATA_O),
        .TABLE_LATCH_O(TABLE_LATCH_O));
    tax_pm_model u_pm (.clk_i(SYS_CLK_I), .long_i(long_q), .addr_i(PM_ADDR_O), .rd_i(PM_RD_O), .wr_i(PM_WR_O),
        .wdata_i(PM_WDATA_O), .rdata_o(PM_RDATA_I), .busy_o(PM_BUSY_I));
    initial begin
        forever #50 SYS_CLK_I = ~SYS_CLK_I;
    end
    always @(posedge SYS_CLK_I) begin
        if (REG_WE_O === 1'b1) begin
            we_seen = 1'b1;
            wd_seen = REG_WDATA_O;
        end
        if (FLUSH_O === 1'b1) fl_seen = 1'b1;
        cyc++;
        if (cyc > 5000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic exec(input logic [15:0] ins, input logic two);
        n = 0;
        we_seen = 1'b0;
        fl_seen = 1'b0;
        INSTR_I = ins;
        NEXT_TWO_WORD_I = two;
        INSTR_VALID_I = 1'b1;
        @(posedge SYS_CLK_I) #1 INSTR_VALID_I = 1'b0;
        @(posedge SYS_CLK_I) #1;
        while (BUSY_O === 1'b1 && n < 200) begin
            n++;
            @(posedge SYS_CLK_I) #1;
        end
        repeat (2) @(posedge SYS_CLK_I) #1;
    endtask : exec
    task automatic t_xor;
        exec({8'h0A, 8'hB5}, 1'b0);
        chk(WORKING_REGISTER_O, 8'hB5);
        chk(FLAGS_O, 2'b10);
        nr = n;
        exec({8'h0A, 8'hB5}, 1'b0);
        chk({WORKING_REGISTER_O, FLAGS_O}, {8'h00, 2'b01});
        exec({8'h0A, 8'hB5}, 1'b0);
        REG_RDATA_I = 8'hAF;
        BANK_SELECT_REGISTER_I = 4'h5;
        exec({6'h06, 1'b1, 1'b0, 8'h20}, 1'b0);
        chk({we_seen, wd_seen, WORKING_REGISTER_O}, {1'b1, 8'h1A, 8'hB5});
        chk(REG_ADDR_O, 12'h020);
        exec({6'h06, 1'b0, 1'b1, 8'h21}, 1'b0);
        chk({we_seen, WORKING_REGISTER_O, FLAGS_O}, {1'b0, 8'h1A, 2'b00});
        chk(REG_ADDR_O, 12'h521);
        $display("done xor");
    endtask : t_xor
    task automatic t_skip;
        REG_RDATA_I = 8'h07;
        exec({7'h33, 1'b1, 8'h30}, 1'b1);
        n1 = n;
        chk(fl_seen, 1'b0);
        REG_RDATA_I = 8'h00;
        exec({7'h33, 1'b0, 8'h30}, 1'b0);
        chk({fl_seen, 32'(n - n1)}, {1'b1, 32'd4});
        exec({7'h33, 1'b0, 8'h30}, 1'b1);
        chk({fl_seen, 32'(n - n1)}, {1'b1, 32'd8});
        $display("done skip");
    endtask : t_skip
    task automatic t_read;
        logic [1:0] opts [6] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h2, 2'h2};
        p = 21'h000000;
        fl_save = FLAGS_O;
        foreach (opts[i]) begin
            if (opts[i] == 2'h3) p = p + 21'h000001;
            lat = p[7:0] ^ 8'h3C;
            if (opts[i] == 2'h1) p = p + 21'h000001;
            if (opts[i] == 2'h2) p = p - 21'h000001;
            exec({14'h0002, opts[i]}, 1'b0);
            chk(TABLE_LATCH_O, lat);
            chk(PM_ADDR_O, p);
            chk(32'(n - nr), 32'd4);
        end
        chk(FLAGS_O, fl_save);
        $display("done read");
    endtask : t_read
    task automatic t_write;
        logic [1:0] opts [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
        fl_save = FLAGS_O;
        foreach (opts[i]) begin
            if (opts[i] == 2'h3) p = p + 21'h000001;
            u_pm.mem[p[7:0]] = ~lat;
            long_q = (i == 3);
            exec({14'h0003, opts[i]}, 1'b0);
            chk(u_pm.mem[p[7:0]], lat);
            if (opts[i] == 2'h1) p = p + 21'h000001;
            if (opts[i] == 2'h2) p = p - 21'h000001;
            chk(PM_ADDR_O, p);
            chk(FLAGS_O, fl_save);
            if (i < 3) chk(32'(n - nr), 32'd4);
            else chk(32'(n - nr > 4), 32'd1);
        end
        $display("done write");
    endtask : t_write
    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (2) @(posedge SYS_CLK_I);
        #1 SRST_I = 1'b0;
        chk({BUSY_O, WORKING_REGISTER_O, TABLE_LATCH_O, PM_ADDR_O}, 38'h0);
        t_xor();
        t_skip();
        t_read();
        t_write();
        complete_run();
    end
endmodule : tb
